// file: design/ctc_top.sv
// camera trigger conditioner: APB registers, sources, filter, delay and queue
`timescale 1ns/1ps
module ctc_top import ctc_pkg::*; #(
   parameter int LINES  = 2,
   parameter int ADDR_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [LINES-1:0]  line_in,
   output logic [LINES-1:0]       line_out,
   output logic [LINES-1:0]       line_oe,
   input  wire logic              cnt_trig,
   output logic                   expose_o,
   output logic                   frame_done_o,
   output logic                   burst_done_o
);
   ctc_seq_if sq ();

   logic [CTRL_W-1:0]  ctrl_q;
   logic [CTRL_W-1:0]  ctrl_d;
   logic [BURST_W-1:0] burst_q;
   logic [BURST_W-1:0] burst_d;
   logic [US_W-1:0]    delay_q;
   logic [US_W-1:0]    delay_d;
   logic [US_W-1:0]    filter_q;
   logic [US_W-1:0]    filter_d;
   logic [US_W-1:0]    frame_q;
   logic [US_W-1:0]    frame_d;
   logic               sw_q;
   logic               sw_d;
   logic [31:0]        prdata_q;
   logic [31:0]        prdata_d;
   logic               pready_q;
   logic               pready_d;
   logic               pslverr_q;
   logic               pslverr_d;
   logic [7:0]         addr;
   logic               wr_en;

   // fields of the control word
   logic               mode_on;
   logic               queue_en;
   ctc_src_e           src;
   ctc_act_e           act;
   logic               line_sel;
   logic [LINES-1:0]   dir_out;

   assign addr     = paddr[7:0];
   assign wr_en    = psel & penable & pready_q & pwrite;
   assign mode_on  = ctrl_q[CTRL_MODE_BIT];
   assign queue_en = ctrl_q[CTRL_QUEUE_BIT];
   assign src      = ctc_src_e'(ctrl_q[CTRL_SRC_LSB +: 2]);
   assign act      = ctc_act_e'(ctrl_q[CTRL_ACT_LSB +: 3]);
   assign line_sel = ctrl_q[CTRL_LSEL_BIT];
   assign dir_out  = ctrl_q[CTRL_DIR_LSB +: LINES];

   function automatic logic reg_known(input logic [7:0] a);
      case (a)
         ADDR_CTRL, ADDR_BURST, ADDR_DELAY, ADDR_FILTER,
         ADDR_SWTRIG, ADDR_STATUS, ADDR_FRAME: reg_known = 1'b1;
         default:                              reg_known = 1'b0;
      endcase
   endfunction

   // refused values are answered with pslverr and leave the register as it was
   function automatic logic wr_ok(input logic [7:0] a, input logic [31:0] d);
      case (a)
         ADDR_CTRL:   wr_ok = (d[CTRL_ACT_LSB +: 3] <= ACT_ANY);
         ADDR_BURST:  wr_ok = (d[31:BURST_W] == '0) && (d[BURST_W-1:0] != '0);
         ADDR_FILTER: wr_ok = (d[31:US_W] == '0) && (d[US_W-1:0] <= FILTER_MAX_US);
         ADDR_STATUS: wr_ok = 1'b0;
         default:     wr_ok = 1'b1;
      endcase
   endfunction

   // queue state, read back through status
   logic [QPTR_W-1:0] qcnt_q;
   logic [QPTR_W:0]   total;

   always_comb
   begin
      ctrl_d    = ctrl_q;
      burst_d   = burst_q;
      delay_d   = delay_q;
      filter_d  = filter_q;
      frame_d   = frame_q;
      sw_d      = 1'b0;
      pready_d  = psel & ~penable;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (psel && !penable)
      begin
         pslverr_d = ~reg_known(addr) | (pwrite & ~wr_ok(addr, pwdata));
         if (!pwrite)
            case (addr)
               ADDR_CTRL:   prdata_d[CTRL_W-1:0]  = ctrl_q;
               ADDR_BURST:  prdata_d[BURST_W-1:0] = burst_q;
               ADDR_DELAY:  prdata_d[US_W-1:0]    = delay_q;
               ADDR_FILTER: prdata_d[US_W-1:0]    = filter_q;
               ADDR_STATUS: prdata_d[4:0] = {total, sq.expose, burst_q == BURST_MIN};
               ADDR_FRAME:  prdata_d[US_W-1:0]    = frame_q;
               default:     prdata_d = 32'h0000_0000;
            endcase
      end
      if (wr_en && !pslverr_q)
         case (addr)
            ADDR_CTRL:   ctrl_d   = pwdata[CTRL_W-1:0];
            ADDR_BURST:  burst_d  = pwdata[BURST_W-1:0];
            ADDR_DELAY:  delay_d  = pwdata[US_W-1:0];
            ADDR_FILTER: filter_d = pwdata[US_W-1:0];
            ADDR_SWTRIG: sw_d     = pwdata[SWTRIG_BIT];
            ADDR_FRAME:  frame_d  = pwdata[US_W-1:0];
            default:     ctrl_d   = ctrl_q;
         endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ctrl_q    <= CTRL_RST;
         burst_q   <= BURST_RST;
         delay_q   <= '0;
         filter_q  <= '0;
         frame_q   <= FRAME_US_RST;
         sw_q      <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         burst_q   <= burst_d;
         delay_q   <= delay_d;
         filter_q  <= filter_d;
         frame_q   <= frame_d;
         sw_q      <= sw_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // microsecond timebase
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic             tick_q;
   logic             tick_d;

   always_comb
   begin
      tick_d = (pre_q == US_LAST);
      pre_d  = tick_d ? '0 : PRE_W'(pre_q + 1'b1);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q  <= pre_d;
         tick_q <= tick_d;
      end
   end

   // line filters, ahead of any edge or level decision
   logic [LINES-1:0] filt_lvl;

   for (genvar i = 0; i < LINES; i++)
   begin : g_filt
      ctc_glitch u_filt (
         .core_clk (core_clk),
         .sys_rst  (sys_rst),
         .us_tick  (tick_q),
         .raw      (line_in[i]),
         .filt_us  (filter_q),
         .level    (filt_lvl[i])
      );
   end

   // trigger sources and activation
   logic prev_q;
   logic sel_lvl;
   logic line_ok;
   logic line_pulse;
   logic level_on;
   logic trig;
   logic hold;

   always_comb
   begin
      sel_lvl = filt_lvl[line_sel];
      // a line set as strobe output never triggers
      line_ok = mode_on & ~dir_out[line_sel]
                & ((src == SRC_LINE) | (src == SRC_ANY));
      case (act)
         ACT_RISE: line_pulse = sel_lvl & ~prev_q;
         ACT_FALL: line_pulse = ~sel_lvl & prev_q;
         ACT_ANY:  line_pulse = sel_lvl ^ prev_q;
         default:  line_pulse = 1'b0;
      endcase
      case (act)
         ACT_HIGH: level_on = sel_lvl;
         ACT_LOW:  level_on = ~sel_lvl;
         default:  level_on = 1'b0;
      endcase
      // software and counter pulses bypass filter and activation
      trig = mode_on & ((sw_q & ((src == SRC_SW) | (src == SRC_ANY)))
                      | (cnt_trig & ((src == SRC_CNT) | (src == SRC_ANY)))
                      | (line_ok & line_pulse));
      hold = ~mode_on | (line_ok & level_on);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         prev_q <= 1'b0;
      else
         prev_q <= sel_lvl;
   end

   // delay and queue: a nonzero slot counts one extra tick, so no delay runs short, except the all-ones delay, which gets no extra tick
   function automatic logic [QPTR_W-1:0] ptr_next(input logic [QPTR_W-1:0] p);
      ptr_next = (p == QPTR_W'(QUEUE_DEPTH - 1)) ? '0 : QPTR_W'(p + 1'b1);
   endfunction

   logic [US_W-1:0]   slot_q [QUEUE_DEPTH];
   logic [US_W-1:0]   slot_d [QUEUE_DEPTH];
   logic [QPTR_W-1:0] wr_q;
   logic [QPTR_W-1:0] wr_d;
   logic [QPTR_W-1:0] rd_q;
   logic [QPTR_W-1:0] rd_d;
   logic [QPTR_W-1:0] qcnt_d;
   logic              start_q;
   logic              start_d;
   logic              accept;
   logic              pop;

   always_comb
   begin
      // a burst counts as running from its start pulse onward
      total  = {1'b0, qcnt_q} + {{QPTR_W{1'b0}}, sq.expose | start_q};
      accept = trig & (queue_en ? (total < (QPTR_W+1)'(QUEUE_DEPTH))
                                : (total == '0));
      // head only, and only once the previous burst has ended
      pop    = mode_on & (qcnt_q != '0) & (slot_q[rd_q] == '0)
               & ~sq.expose & ~start_q;
      start_d = pop;
      wr_d    = accept ? ptr_next(wr_q) : wr_q;
      rd_d    = pop ? ptr_next(rd_q) : rd_q;
      qcnt_d  = QPTR_W'(qcnt_q + accept - pop);
      if (!mode_on)
      begin
         wr_d   = '0;
         rd_d   = '0;
         qcnt_d = '0;
      end
   end

   for (genvar i = 0; i < QUEUE_DEPTH; i++)
   begin : g_slot
      always_comb
      begin
         if (accept && (wr_q == QPTR_W'(i)))
            slot_d[i] = (delay_q == '0 || &delay_q) ? delay_q : US_W'(delay_q + 1'b1);
         else if (tick_q && (slot_q[i] != '0))
            slot_d[i] = US_W'(slot_q[i] - 1'b1);
         else
            slot_d[i] = slot_q[i];
      end

      always_ff @(posedge core_clk)
      begin
         if (sys_rst)
            slot_q[i] <= '0;
         else
            slot_q[i] <= slot_d[i];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         qcnt_q  <= '0;
         start_q <= 1'b0;
      end
      else
      begin
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         qcnt_q  <= qcnt_d;
         start_q <= start_d;
      end
   end

   // exposure sequencer
   assign sq.start    = start_q;
   assign sq.hold     = hold;
   assign sq.us_tick  = tick_q;
   assign sq.frames   = burst_q;
   assign sq.frame_us = frame_q;

   ctc_seq u_seq (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .sq       (sq)
   );

   // line pins: strobe lines show the exposure window
   logic [LINES-1:0] line_out_q;
   logic [LINES-1:0] line_out_d;
   logic [LINES-1:0] line_oe_q;
   logic [LINES-1:0] line_oe_d;

   always_comb
   begin
      line_oe_d  = dir_out;
      line_out_d = dir_out & {LINES{sq.expose}};
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         line_out_q <= '0;
         line_oe_q  <= '0;
      end
      else
      begin
         line_out_q <= line_out_d;
         line_oe_q  <= line_oe_d;
      end
   end

   assign line_out     = line_out_q;
   assign line_oe      = line_oe_q;
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign expose_o     = sq.expose;
   assign frame_done_o = sq.frame_done;
   assign burst_done_o = sq.burst_done;
endmodule

// file: design/ctc_pkg.sv
// constants and types shared by the camera trigger conditioner files
package ctc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
   localparam int PRE_W         = 7;
   localparam logic [PRE_W-1:0] US_LAST = PRE_W'(US_CYCLES - 1);
   localparam int US_W          = 20;
   localparam int BURST_W       = 10;
   localparam int QUEUE_DEPTH   = 3;
   localparam int QPTR_W        = 2;
   localparam int CTRL_W        = 10;
   localparam logic [BURST_W-1:0] BURST_MIN     = 10'h001;
   localparam logic [BURST_W-1:0] BURST_RST     = 10'h001;
   localparam logic [US_W-1:0]    FILTER_MAX_US = 20'hF4240;
   localparam logic [US_W-1:0]    FRAME_US_RST  = 20'h0000A;
   localparam logic [CTRL_W-1:0]  CTRL_RST      = 10'h000;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BURST  = 8'h04;
   localparam logic [7:0] ADDR_DELAY  = 8'h08;
   localparam logic [7:0] ADDR_FILTER = 8'h0C;
   localparam logic [7:0] ADDR_SWTRIG = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FRAME  = 8'h18;
   // control field positions
   localparam int CTRL_MODE_BIT  = 0;
   localparam int CTRL_QUEUE_BIT = 1;
   localparam int CTRL_SRC_LSB   = 2;
   localparam int CTRL_ACT_LSB   = 4;
   localparam int CTRL_LSEL_BIT  = 7;
   localparam int CTRL_DIR_LSB   = 8;
   localparam int SWTRIG_BIT     = 0;
   typedef enum logic [1:0] {SRC_SW, SRC_LINE, SRC_CNT, SRC_ANY} ctc_src_e;
   typedef enum logic [2:0] {ACT_RISE, ACT_FALL, ACT_HIGH, ACT_LOW, ACT_ANY} ctc_act_e;
endpackage

// file: design/ctc_seq_if.sv
// link between trigger control and the exposure sequencer
`timescale 1ns/1ps
interface ctc_seq_if import ctc_pkg::*; ();
   logic               start;
   logic               hold;
   logic               us_tick;
   logic [BURST_W-1:0] frames;
   logic [US_W-1:0]    frame_us;
   logic               expose;
   logic               frame_done;
   logic               burst_done;
   modport ctrl (output start, hold, us_tick, frames, frame_us,
                 input  expose, frame_done, burst_done);
   modport seq  (input  start, hold, us_tick, frames, frame_us,
                 output expose, frame_done, burst_done);
endinterface

// file: design/ctc_glitch.sv
// line glitch filter: a level change must persist for the filter time
`timescale 1ns/1ps
module ctc_glitch import ctc_pkg::*; (
   input  wire logic            core_clk,
   input  wire logic            sys_rst,
   input  wire logic            us_tick,
   input  wire logic            raw,
   input  wire logic [US_W-1:0] filt_us,
   output logic                 level
);
   logic [US_W-1:0] cnt_q;
   logic [US_W-1:0] cnt_d;
   logic            level_q;
   logic            level_d;

   always_comb
   begin
      cnt_d   = cnt_q;
      level_d = level_q;
      if (raw == level_q)
         cnt_d = '0;
      else if (cnt_q >= filt_us)
      begin
         level_d = raw;
         cnt_d   = '0;
      end
      else if (us_tick)
         cnt_d = US_W'(cnt_q + 1'b1);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cnt_q   <= '0;
         level_q <= 1'b0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule

// file: design/ctc_seq.sv
// exposure sequencer: runs bursts of frames or free-runs while held
`timescale 1ns/1ps
module ctc_seq import ctc_pkg::*; (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   ctc_seq_if.seq    sq
);
   typedef enum logic {SQ_IDLE, SQ_FRAME} ctc_sq_e;

   ctc_sq_e            st_q;
   ctc_sq_e            st_d;
   logic [BURST_W-1:0] left_q;
   logic [BURST_W-1:0] left_d;
   logic [US_W-1:0]    us_q;
   logic [US_W-1:0]    us_d;
   logic               burst_q;
   logic               burst_d;
   logic               done_q;
   logic               done_d;
   logic               bdone_q;
   logic               bdone_d;
   logic               exp_q;

   always_comb
   begin
      st_d    = st_q;
      left_d  = left_q;
      us_d    = us_q;
      burst_d = burst_q;
      done_d  = 1'b0;
      bdone_d = 1'b0;
      case (st_q)
         SQ_IDLE:
            if (sq.start || sq.hold)
            begin
               st_d    = SQ_FRAME;
               left_d  = sq.start ? sq.frames : BURST_MIN;
               burst_d = sq.start;
               us_d    = '0;
            end
         SQ_FRAME:
            if (sq.us_tick)
            begin
               // a zero frame time still gives one microsecond per frame
               if (US_W'(us_q + 1'b1) >= sq.frame_us)
               begin
                  done_d = 1'b1;
                  us_d   = '0;
                  if (left_q > BURST_MIN)
                     left_d = BURST_W'(left_q - 1'b1);
                  else if (sq.hold)
                  begin
                     left_d  = BURST_MIN;
                     burst_d = 1'b0;
                  end
                  else
                  begin
                     st_d    = SQ_IDLE;
                     bdone_d = burst_q;
                  end
               end
               else
                  us_d = US_W'(us_q + 1'b1);
            end
         default:
            st_d = SQ_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st_q    <= SQ_IDLE;
         left_q  <= BURST_MIN;
         us_q    <= '0;
         burst_q <= 1'b0;
         done_q  <= 1'b0;
         bdone_q <= 1'b0;
         exp_q   <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         left_q  <= left_d;
         us_q    <= us_d;
         burst_q <= burst_d;
         done_q  <= done_d;
         bdone_q <= bdone_d;
         exp_q   <= (st_d == SQ_FRAME);
      end
   end

   assign sq.expose     = exp_q;
   assign sq.frame_done = done_q;
   assign sq.burst_done = bdone_q;
endmodule

// file: testbench/ctc_top_sva.sv
// port assertions for the camera trigger conditioner
`timescale 1ns/1ps
module ctc_top_chk import ctc_pkg::*; #(
   parameter int LINES  = 2,
   parameter int ADDR_W = 8
) (
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [LINES-1:0]  line_in,
   input wire logic [LINES-1:0]  line_out,
   input wire logic [LINES-1:0]  line_oe,
   input wire logic              cnt_trig,
   input wire logic              expose_o,
   input wire logic              frame_done_o,
   input wire logic              burst_done_o
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   frame_end_a: assert property (frame_done_o |-> $past(expose_o) ##1 !frame_done_o)
      else $error("frame end without exposure");
   burst_last_a: assert property (burst_done_o |-> frame_done_o ##1 !expose_o)
      else $error("burst end misplaced");
   strobe_only_a: assert property ((line_out & ~line_oe) == '0)
      else $error("undriven line toggles");
   strobe_copy_a: assert property (line_oe[LINES-1] && $past(line_oe[LINES-1])
      |-> line_out[LINES-1] == $past(expose_o)) else $error("strobe not exposure");
   cover property (burst_done_o);
   cover property (pslverr);
   cover property (line_oe[LINES-1] && expose_o);
endmodule

bind ctc_top ctc_top_chk #(.LINES(LINES), .ADDR_W(ADDR_W)) i_ctc_top_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
   .cnt_trig(cnt_trig), .expose_o(expose_o), .frame_done_o(frame_done_o),
   .burst_done_o(burst_done_o));

// file: testbench/ctc_src_model.sv
// external trigger source: line levels and counter pulses
`timescale 1ns/1ps
module ctc_src_model (
   input  wire logic core_clk,
   output logic [1:0] line_drv,
   output logic       cnt_trig
);
   initial
   begin
      line_drv = 2'h0;
      cnt_trig = 1'b0;
   end
   // caller keeps pulses longer than the filter when a trigger is meant
   task automatic hold(input logic v, input int n);
      line_drv[0] <= v;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic cnt_pulse;
      cnt_trig <= 1'b1;
      @(posedge core_clk);
      cnt_trig <= 1'b0;
      @(posedge core_clk);
   endtask
endmodule

// file: testbench/tb.sv
// register-level testbench for the camera trigger conditioner
`timescale 1ns/1ps
module tb import ctc_pkg::*;;
   logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic        cnt_trig, expose_o, frame_done_o, burst_done_o;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  line_in, line_out, line_oe, drv;
   int          fails, checked, nfr, nbu, f0, b0, n;
   ctc_top i_ctc_top (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
      .line_out(line_out), .line_oe(line_oe), .cnt_trig(cnt_trig), .expose_o(expose_o),
      .frame_done_o(frame_done_o), .burst_done_o(burst_done_o));
   ctc_src_model i_ctc_src_model (.core_clk(core_clk), .line_drv(drv), .cnt_trig(cnt_trig));
   // a line in strobe direction carries the device's level
   assign line_in = (line_oe & line_out) | (~line_oe & drv);
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (frame_done_o === 1'b1) nfr++;
      if (burst_done_o === 1'b1) nbu++;
   end
   task automatic conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         fails++;
         conclude();
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, d, r, er);
      cmp(32'(er), 32'(ee));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0, r, er);
      cmp(r, ex);
   endtask
   function automatic logic [31:0] ctl(input logic q, input logic [1:0] s, input logic [2:0] a);
      return {22'h0, 2'b10, 1'b0, a, s, q, 1'b1};
   endfunction
   task automatic mark;
      f0 = nfr;
      b0 = nbu;
   endtask
   // idle means 300 cycles without exposure, longer than one frame gap
   task automatic tally(input int ef, input int eb);
      int q, k;
      q = 0;
      k = 0;
      while (q < 300 && k < 30000)
      begin
         @(posedge core_clk);
         k++;
         q = (expose_o === 1'b1) ? 0 : q + 1;
      end
      if (q < 300)
      begin
         fails++;
         conclude();
      end
      if (ef >= 0) cmp(nfr - f0, ef);
      if (eb >= 0) cmp(nbu - b0, eb);
   endtask
   initial
   begin
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; fails = 0; checked = 0; nfr = 0; nbu = 0;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_BURST, 32'h1);
      rd(ADDR_DELAY, 32'h0);
      rd(ADDR_FILTER, 32'h0);
      rd(ADDR_FRAME, 32'hA);
      mark();
      i_ctc_src_model.cnt_pulse();
      repeat (3000) @(posedge core_clk);
      cmp(32'(nfr - f0 > 1), 32'h1);
      cmp(nbu - b0, 32'h0);
      wr(ADDR_BURST, 32'h0, 1'b1);
      wr(ADDR_BURST, 32'h400, 1'b1);
      rd(ADDR_BURST, 32'h1);
      wr(ADDR_BURST, 32'h3FF, 1'b0);
      rd(ADDR_BURST, 32'h3FF);
      wr(ADDR_FILTER, 32'hF4241, 1'b1);
      wr(ADDR_FILTER, 32'hF4240, 1'b0);
      wr(ADDR_CTRL, 32'h70, 1'b1);
      wr(8'h1C, 32'h5, 1'b1);
      rd(8'h1C, 32'h0);
      wr(ADDR_STATUS, 32'h0, 1'b1);
      wr(ADDR_FRAME, 32'h1, 1'b0);
      wr(ADDR_BURST, 32'h3, 1'b0);
      wr(ADDR_FILTER, 32'h2, 1'b0);
      wr(ADDR_CTRL, ctl(1'b0, SRC_SW, ACT_FALL), 1'b0);
      // the pin enables follow the control word one clock later
      @(posedge core_clk);
      cmp(32'(line_oe), 32'h2);
      tally(-1, -1);
      mark();
      wr(ADDR_SWTRIG, 32'h1, 1'b0);
      wr(ADDR_SWTRIG, 32'h1, 1'b0);
      tally(3, 1);
      rd(ADDR_STATUS, 32'h0);
      wr(ADDR_BURST, 32'h1, 1'b0);
      rd(ADDR_STATUS, 32'h1);
      wr(ADDR_BURST, 32'h2, 1'b0);
      wr(ADDR_CTRL, ctl(1'b1, SRC_SW, ACT_RISE), 1'b0);
      mark();
      repeat (4) wr(ADDR_SWTRIG, 32'h1, 1'b0);
      tally(6, 3);
      wr(ADDR_CTRL, ctl(1'b0, SRC_CNT, ACT_FALL), 1'b0);
      mark();
      i_ctc_src_model.cnt_pulse();
      tally(2, 1);
      wr(ADDR_DELAY, 32'h5, 1'b0);
      wr(ADDR_CTRL, ctl(1'b0, SRC_SW, ACT_RISE), 1'b0);
      wr(ADDR_SWTRIG, 32'h1, 1'b0);
      n = 0;
      while (expose_o !== 1'b1 && n < 1000)
      begin
         @(posedge core_clk);
         n++;
      end
      cmp(32'(n >= 490 && n <= 700), 32'h1);
      wr(ADDR_DELAY, 32'h0, 1'b0);
      wr(ADDR_BURST, 32'h1, 1'b0);
      wr(ADDR_CTRL, ctl(1'b0, SRC_LINE, ACT_RISE), 1'b0);
      tally(-1, -1);
      mark();
      i_ctc_src_model.hold(1'b1, 100);
      i_ctc_src_model.hold(1'b0, 1);
      tally(0, 0);
      // rising, falling and any edge: one long pulse each
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_CTRL, ctl(1'b0, SRC_LINE, i == 0 ? ACT_RISE : i == 1 ? ACT_FALL : ACT_ANY),
            1'b0);
         mark();
         i_ctc_src_model.hold(1'b1, 600);
         i_ctc_src_model.hold(1'b0, 1);
         tally(i == 2 ? 2 : 1, i == 2 ? 2 : 1);
      end
      wr(ADDR_CTRL, ctl(1'b0, SRC_LINE, ACT_HIGH), 1'b0);
      mark();
      i_ctc_src_model.hold(1'b1, 1000);
      i_ctc_src_model.hold(1'b0, 1);
      tally(-1, -1);
      cmp(32'(nfr - f0 >= 5), 32'h1);
      i_ctc_src_model.hold(1'b1, 600);
      wr(ADDR_CTRL, ctl(1'b0, SRC_LINE, ACT_LOW), 1'b0);
      mark();
      i_ctc_src_model.hold(1'b0, 1000);
      i_ctc_src_model.hold(1'b1, 1);
      tally(-1, -1);
      cmp(32'(nfr - f0 >= 5), 32'h1);
      conclude();
   end
endmodule
